/* verilog/pof_pkg.sv */
package pof_pkg;

  // Output format codes held in the control register.
  localparam logic [2:0] fmt_gray_8bit         = 3'h0;
  localparam logic [2:0] fmt_gray_16bit        = 3'h1;
  localparam logic [2:0] fmt_luma_chroma_422   = 3'h2;
  localparam logic [2:0] fmt_unprocessed_8bit  = 3'h3;
  localparam logic [2:0] fmt_unprocessed_16bit = 3'h4;

  // Register byte offsets and fields.
  localparam logic [11:0] POF_CTRL_OFS   = 12'h000;
  localparam logic [11:0] POF_STATUS_OFS = 12'h004;
  localparam int          POF_CTRL_FMT_LSB  = 0;
  localparam int          POF_CTRL_EN_BIT   = 3;
  localparam logic [2:0]  POF_CTRL_FMT_RST  = 3'h0;
  localparam logic        POF_CTRL_EN_RST   = 1'b0;
  localparam int          POF_ST_BAD_BIT    = 0;
  localparam int          POF_ST_BUSY_BIT   = 1;
  localparam int          POF_ST_FMT_LSB    = 2;
  localparam int          POF_ST_FRAMES_LSB = 16;

  // Colour conversion coefficients in hundredths.
  localparam int POF_Y_R  = 30;
  localparam int POF_Y_G  = 59;
  localparam int POF_Y_B  = 11;
  localparam int POF_U_R  = -17;
  localparam int POF_U_G  = -33;
  localparam int POF_U_B  = 50;
  localparam int POF_V_R  = 50;
  localparam int POF_V_G  = -41;
  localparam int POF_V_B  = -9;
  localparam int POF_DIV  = 100;
  localparam int POF_HALF = 50;
  localparam int POF_CHROMA_OFS = 128;
  localparam int POF_BYTE_MAX   = 255;

  // Bytes emitted per output unit.
  localparam logic [2:0] POF_BYTES_8   = 3'h1;
  localparam logic [2:0] POF_BYTES_16  = 3'h2;
  localparam logic [2:0] POF_BYTES_422 = 3'h4;

  // Mosaic colour of a site.
  localparam logic [1:0] POF_COL_R = 2'h0;
  localparam logic [1:0] POF_COL_G = 2'h1;
  localparam logic [1:0] POF_COL_B = 2'h2;

  // One sensor sample with its framing marks.
  typedef struct packed {
    logic        sof;
    logic        eol;
    logic [11:0] data;
  } pof_pix_s;

endpackage

/* verilog/pof_formatter.sv */
`timescale 1ns/100ps

// How it works
// - Gray 8: one byte per pixel.
// - 16-bit formats: word per pixel, 10/12 effective.
// - Effective bits right-aligned, upper bits zero.
// - 16-bit words sent high byte first.
// - Format comes from control register field.
// - High-speed variants restrict the allowed formats.
// - CMOS mosaic: G B row, then R G.
// - CCD mosaic: R G row, then G B.
// - Unprocessed 8: own sample, eight bits.
// - Unprocessed 16: own sample, effective bits only.
// - Colour formats interpolate full RGB first.
// - Luma is 0.30R + 0.59G + 0.11B.
// - Blue chroma is -0.17R - 0.33G + 0.50B.
// - Red chroma is 0.50R - 0.41G - 0.09B.
// - Chroma offset by 128 to unsigned.
// - YUV mode sends 4:2:2 subsampled chroma.
// - Colour gray 8 sends luma only.
// - 4:2:2 components eight bits, 16 bits average.
module pof_formatter
  import pof_pkg::*;
#(
  parameter int DEPTH      = 12,
  parameter bit COLOUR     = 1'b1,
  parameter bit CCD        = 1'b0,
  parameter bit HIGH_SPEED = 1'b0,
  parameter int MAX_WIDTH  = 2048
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire pof_pix_s    pix_in,
  input  wire logic        pix_valid,
  output logic             pix_ready,
  output logic      [7:0]  out_byte,
  output logic             out_valid,
  input  wire logic        out_ready
);

  localparam int CW = $clog2(MAX_WIDTH);
  localparam logic [11:0] MASK = 12'((1 << DEPTH) - 1);

  // Reduces an effective-width sample to its top eight bits.
  function automatic logic [7:0] to8(input logic [11:0] v);
    to8 = 8'(v >> (DEPTH - 8));
  endfunction

  // Mosaic colour of a site from its row and column parity.
  function automatic logic [1:0] site_col(input logic rp, input logic cp);
    if (CCD)
      site_col = rp ? (cp ? POF_COL_B : POF_COL_G) : (cp ? POF_COL_G : POF_COL_R);
    else
      site_col = rp ? (cp ? POF_COL_G : POF_COL_R) : (cp ? POF_COL_B : POF_COL_G);
  endfunction

  // Luma with rounding; used at full depth and at eight bits.
  function automatic logic [11:0] luma(input logic [11:0] r, input logic [11:0] g, input logic [11:0] b);
    int s;
    s = POF_Y_R * int'(r) + POF_Y_G * int'(g) + POF_Y_B * int'(b) + POF_HALF;
    luma = 12'(s / POF_DIV);
  endfunction

  // Signed chroma rounded to nearest, offset and clamped to a byte.
  function automatic logic [7:0] chroma(input int kr, input int kg, input int kb,
                                         input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
    int s;
    int q;
    s = kr * int'(r) + kg * int'(g) + kb * int'(b);
    q = (s >= 0) ? (s + POF_HALF) / POF_DIV : (s - POF_HALF) / POF_DIV;
    q = q + POF_CHROMA_OFS;
    if (q < 0)
      q = 0;
    if (q > POF_BYTE_MAX)
      q = POF_BYTE_MAX;
    chroma = 8'(q);
  endfunction

  // Which formats the built variant offers.
  function automatic logic fmt_ok(input logic [2:0] f);
    if (!COLOUR)
      fmt_ok = (f == fmt_gray_8bit) || (!HIGH_SPEED && f == fmt_gray_16bit);
    else if (HIGH_SPEED)
      fmt_ok = (f == fmt_gray_8bit) || (f == fmt_unprocessed_8bit);
    else
      fmt_ok = (f <= fmt_unprocessed_16bit);
  endfunction

  logic [2:0]    fmt_reg, fmt_next;
  logic          en_reg, en_next;
  logic [2:0]    act_reg, act_next;
  logic [15:0]   frames_reg, frames_next;
  logic [31:0]   prdata_reg, prdata_next;
  logic [31:0]   hold_reg, hold_next;
  logic [2:0]    cnt_reg, cnt_next;
  logic [CW-1:0] col_reg, col_next;
  logic [15:0]   row_reg, row_next;
  logic [11:0]   left_reg, left_next;
  logic [11:0]   upl_reg, upl_next;
  logic          odd_reg, odd_next;
  logic [7:0]    u_reg, u_next;
  logic [7:0]    v_reg, v_next;
  logic [7:0]    y0_reg, y0_next;
  logic [11:0]   line_mem [MAX_WIDTH];

  logic          acc, wr, rd_setup, addr_hit, fmt_bad;
  logic [2:0]    fmt_use;
  logic [CW-1:0] cur_col;
  logic [15:0]   cur_row;
  logic [11:0]   cur, up_raw, left_e, up_e, ul_e, rv, gv, bv, y_full;
  logic [12:0]   gsum;
  logic [7:0]    y8, u8, v8;
  logic [11:0]   win [4];
  logic [1:0]    wcol;

  // APB handshake: zero wait states, error only on unmapped offsets.
  assign addr_hit  = (paddr == POF_CTRL_OFS) || (paddr == POF_STATUS_OFS);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !addr_hit;
  assign prdata    = prdata_reg;
  assign wr        = psel && penable && pwrite && addr_hit;
  assign rd_setup  = psel && !penable && !pwrite;
  assign fmt_bad   = !fmt_ok(fmt_reg);

  // Output stream: top byte of the holding word, valid while bytes remain.
  assign out_byte  = hold_reg[31:24];
  assign out_valid = (cnt_reg != 3'h0);
  // While enabled, a new pixel is taken only once at most one byte is left and it leaves now; while disabled, any pixel is taken.
  assign pix_ready = !en_reg || (cnt_reg == 3'h0) || (cnt_reg == 3'h1 && out_ready);
  assign acc       = pix_valid && pix_ready;

  // Frame start latches the format so a mid-frame write cannot tear an image.
  assign fmt_use = pix_in.sof ? (fmt_bad ? fmt_gray_8bit : fmt_reg) : act_reg;
  assign cur_col = pix_in.sof ? '0 : col_reg;
  assign cur_row = pix_in.sof ? 16'h0 : row_reg;
  assign cur     = pix_in.data & MASK;
  assign up_raw  = line_mem[cur_col];

  // 2x2 window; at the image edges the missing neighbours repeat nearer samples.
  always_comb
  begin
    left_e = (cur_col == '0) ? cur : left_reg;
    up_e   = (cur_row == 16'h0) ? cur : up_raw;
    ul_e   = (cur_row == 16'h0) ? left_e : ((cur_col == '0) ? up_e : upl_reg);
    win[0] = cur;
    win[1] = left_e;
    win[2] = up_e;
    win[3] = ul_e;
  end

  // Each colour is taken from its own site in the window; greens are averaged.
  always_comb
  begin
    rv   = cur;
    bv   = cur;
    gsum = 13'h0;
    wcol = POF_COL_G;
    for (int i = 0; i < 4; i++)
    begin
      wcol = site_col(cur_row[0] ^ i[1], cur_col[0] ^ i[0]);
      if (wcol == POF_COL_R)
        rv = win[i];
      else if (wcol == POF_COL_B)
        bv = win[i];
      else
        gsum = gsum + {1'b0, win[i]};
    end
    gv     = gsum[12:1];
    y_full = luma(rv, gv, bv);
    y8     = 8'(luma({4'h0, to8(rv)}, {4'h0, to8(gv)}, {4'h0, to8(bv)}));
    u8     = chroma(POF_U_R, POF_U_G, POF_U_B, to8(rv), to8(gv), to8(bv));
    v8     = chroma(POF_V_R, POF_V_G, POF_V_B, to8(rv), to8(gv), to8(bv));
  end

  // Register file next state and registered read data.
  always_comb
  begin
    fmt_next    = fmt_reg;
    en_next     = en_reg;
    prdata_next = prdata_reg;
    if (wr && paddr == POF_CTRL_OFS)
    begin
      fmt_next = pwdata[POF_CTRL_FMT_LSB +: 3];
      en_next  = pwdata[POF_CTRL_EN_BIT];
    end
    if (rd_setup)
    begin
      prdata_next = 32'h0;
      if (paddr == POF_CTRL_OFS)
      begin
        prdata_next[POF_CTRL_FMT_LSB +: 3] = fmt_reg;
        prdata_next[POF_CTRL_EN_BIT]       = en_reg;
      end
      else if (paddr == POF_STATUS_OFS)
      begin
        prdata_next[POF_ST_BAD_BIT]            = fmt_bad;
        prdata_next[POF_ST_BUSY_BIT]           = out_valid;
        prdata_next[POF_ST_FMT_LSB +: 3]       = act_reg;
        prdata_next[POF_ST_FRAMES_LSB +: 16]   = frames_reg;
      end
    end
  end

  // Pixel path next state: position, window history, pairing and byte holder.
  always_comb
  begin
    act_next    = act_reg;
    frames_next = frames_reg;
    col_next    = col_reg;
    row_next    = row_reg;
    left_next   = left_reg;
    upl_next    = upl_reg;
    odd_next    = odd_reg;
    u_next      = u_reg;
    v_next      = v_reg;
    y0_next     = y0_reg;
    hold_next   = hold_reg;
    cnt_next    = cnt_reg;
    if (out_valid && out_ready)
    begin
      hold_next = {hold_reg[23:0], 8'h00};
      cnt_next  = cnt_reg - 3'h1;
    end
    if (acc)
    begin
      act_next  = fmt_use;
      left_next = cur;
      upl_next  = up_raw;
      if (pix_in.sof)
        frames_next = frames_reg + 16'h1;
      if (pix_in.eol)
      begin
        col_next = '0;
        row_next = cur_row + 16'h1;
      end
      else
      begin
        col_next = cur_col + CW'(1);
        row_next = cur_row;
      end
    end
    if (acc && en_reg)
    begin
      unique case (fmt_use)
        fmt_gray_8bit:
        begin
          hold_next = {COLOUR ? y8 : to8(cur), 24'h0};
          cnt_next  = POF_BYTES_8;
        end
        fmt_gray_16bit:
        begin
          hold_next = {4'h0, COLOUR ? y_full : cur, 16'h0};
          cnt_next  = POF_BYTES_16;
        end
        fmt_unprocessed_8bit:
        begin
          hold_next = {to8(cur), 24'h0};
          cnt_next  = POF_BYTES_8;
        end
        fmt_unprocessed_16bit:
        begin
          hold_next = {4'h0, cur, 16'h0};
          cnt_next  = POF_BYTES_16;
        end
        fmt_luma_chroma_422:
        begin
          // A line of odd width closes its last pair with the lone luma twice.
          if (!odd_reg && !pix_in.eol && !pix_in.sof)
          begin
            u_next   = u8;
            v_next   = v8;
            y0_next  = y8;
            odd_next = 1'b1;
          end
          else if (!odd_reg || pix_in.sof)
          begin
            hold_next = {u8, y8, v8, y8};
            cnt_next  = POF_BYTES_422;
            odd_next  = 1'b0;
          end
          else
          begin
            hold_next = {u_reg, y0_reg, v_reg, y8};
            cnt_next  = POF_BYTES_422;
            odd_next  = 1'b0;
          end
        end
        default:
        begin
          hold_next = {to8(cur), 24'h0};
          cnt_next  = POF_BYTES_8;
        end
      endcase
      if (fmt_use == fmt_luma_chroma_422 && pix_in.sof && !pix_in.eol)
      begin
        // A frame start opens a fresh pair instead of closing a stale one.
        u_next    = u8;
        v_next    = v8;
        y0_next   = y8;
        odd_next  = 1'b1;
        hold_next = hold_reg;
        cnt_next  = (out_valid && out_ready) ? cnt_reg - 3'h1 : cnt_reg;
      end
    end
  end

  // All state registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fmt_reg    <= POF_CTRL_FMT_RST;
      en_reg     <= POF_CTRL_EN_RST;
      act_reg    <= fmt_gray_8bit;
      frames_reg <= 16'h0;
      prdata_reg <= 32'h0;
      hold_reg   <= 32'h0;
      cnt_reg    <= 3'h0;
      col_reg    <= '0;
      row_reg    <= 16'h0;
      left_reg   <= 12'h0;
      upl_reg    <= 12'h0;
      odd_reg    <= 1'b0;
      u_reg      <= 8'h0;
      v_reg      <= 8'h0;
      y0_reg     <= 8'h0;
    end
    else
    begin
      fmt_reg    <= fmt_next;
      en_reg     <= en_next;
      act_reg    <= act_next;
      frames_reg <= frames_next;
      prdata_reg <= prdata_next;
      hold_reg   <= hold_next;
      cnt_reg    <= cnt_next;
      col_reg    <= col_next;
      row_reg    <= row_next;
      left_reg   <= left_next;
      upl_reg    <= upl_next;
      odd_reg    <= odd_next;
      u_reg      <= u_next;
      v_reg      <= v_next;
      y0_reg     <= y0_next;
    end
  end

  // Previous-line store; memory needs no reset since row zero never reads it.
  always_ff @(posedge pclk)
  begin
    if (acc)
      line_mem[cur_col] <= cur;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_gray8_one_byte : assert property (
    acc && en_reg && fmt_use == fmt_gray_8bit |=> cnt_reg == POF_BYTES_8 ##1 !out_valid || $past(pix_ready))
    else $error("gray 8 did not yield exactly one byte");

  a_word_msb_first : assert property (
    acc && en_reg && fmt_use == fmt_unprocessed_16bit
    |=> out_byte == {4'h0, $past(cur[11:8])}
    ##1 out_byte == ($past(out_ready) ? $past(cur[7:0], 2) : {4'h0, $past(cur[11:8], 2)}))
    else $error("16-bit word not sent high byte first");

  a_upper_zero : assert property (
    acc && en_reg && (fmt_use == fmt_gray_16bit || fmt_use == fmt_unprocessed_16bit)
    |=> cnt_reg == POF_BYTES_16 && (hold_reg[31:16] >> DEPTH) == 16'h0)
    else $error("bits above effective width not zero");

  a_raw8_sample : assert property (
    acc && en_reg && fmt_use == fmt_unprocessed_8bit |=> out_byte == to8($past(cur)))
    else $error("unprocessed 8 byte differs from sample");

  a_bad_fallback : assert property (
    acc && pix_in.sof && fmt_bad |=> act_reg == fmt_gray_8bit)
    else $error("disallowed format was used");

  a_pair_order : assert property (
    acc && en_reg && fmt_use == fmt_luma_chroma_422 && odd_reg && !pix_in.sof
    |=> cnt_reg == POF_BYTES_422 && out_byte == $past(u_reg) && hold_reg[7:0] == $past(y8))
    else $error("4:2:2 pair not in U Y0 V Y1 order");

  a_pair_holds : assert property (
    out_valid && cnt_reg > 3'h1 |-> !pix_ready ##1 out_valid)
    else $error("pixel accepted while bytes pending");

  a_luma_round : assert property (
    acc && en_reg && COLOUR && fmt_use == fmt_gray_8bit
    |=> out_valid && out_byte == $past(8'((POF_Y_R * int'(to8(rv)) + POF_Y_G * int'(to8(gv))
                                           + POF_Y_B * int'(to8(bv)) + POF_HALF) / POF_DIV)))
    else $error("colour gray byte missing");

  a_unmapped_err : assert property (
    psel && penable && !addr_hit |-> pslverr && pready)
    else $error("unmapped access not refused");

endmodule // pof_formatter

/* test/pof_sink_model.sv */
`timescale 1ns/100ps

// Byte sink in the place of the processor core; in slow mode it stalls one cycle in three.
module pof_sink_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       slow,
  input  wire logic [7:0] out_byte,
  input  wire logic       out_valid,
  output logic            out_ready
);
  logic [7:0] got[$];
  logic [1:0] phase;

  // A byte is taken only at an edge where valid and ready are both high.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase     <= 2'h0;
      out_ready <= 1'b0;
    end
    else
    begin
      if (out_valid && out_ready)
      begin
        got.push_back(out_byte);
      end
      phase     <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      out_ready <= !(slow && phase == 2'h1);
    end
  end
endmodule // pof_sink_model

/* test/pixel_output_formatter_bench.sv */
`timescale 1ns/100ps

module pixel_output_formatter_bench
  import pof_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  pof_pix_s    pix_in;
  logic        pix_valid;
  logic        pix_ready;
  logic [7:0]  out_byte;
  logic        out_valid;
  logic        out_ready;
  logic        slow;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  exp_q[$];
  int          n_mismatch;
  int          cmp_count;
  int          cycles;

  // Depth, sensor kind and speed grade stay at their defaults; only the line store is shrunk.
  pof_formatter #(.MAX_WIDTH(16)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_in(pix_in),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .out_byte(out_byte), .out_valid(out_valid),
    .out_ready(out_ready)
  );

  pof_sink_model sink (
    .pclk(pclk), .presetn(presetn), .slow(slow), .out_byte(out_byte), .out_valid(out_valid),
    .out_ready(out_ready)
  );

  // The clock runs at 10 MHz.
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    begin
      cmp_count++;
      if (seen !== exp)
      begin
        n_mismatch++;
        $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
    end
  endtask

  task automatic complete_run();
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    begin
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= addr;
      pwdata <= wdata;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
        @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Sends a w by h frame, pixel i carrying base plus i times step; valid stays up between pixels.
  task automatic send_frame(input int w, input int h, input logic [11:0] base, input logic [11:0] step);
    int i;
    begin
      for (i = 0; i < w * h; i++)
      begin
        pix_in    <= '{sof: (i == 0), eol: (i % w == w - 1), data: base + 12'(i) * step};
        pix_valid <= 1'b1;
        @(posedge pclk);
        while (pix_ready !== 1'b1)
        begin
          @(posedge pclk);
        end
      end
      pix_valid <= 1'b0;
    end
  endtask

  // Waits for the expected bytes, lets stray extras arrive, then compares count and content.
  task automatic check_out(input string what);
    int i;
    begin
      while (sink.got.size() < exp_q.size())
      begin
        @(posedge pclk);
      end
      repeat (6) @(posedge pclk);
      chk(32'(sink.got.size()), 32'(exp_q.size()), what);
      for (i = 0; i < exp_q.size() && i < sink.got.size(); i++)
      begin
        chk({24'h0, sink.got[i]}, {24'h0, exp_q[i]}, what);
      end
      sink.got.delete();
      exp_q.delete();
    end
  endtask

  // Reset values, read-back of the format field, and an unmapped offset.
  task automatic t_regs();
    begin
      apb(1'b0, POF_CTRL_OFS, 32'h0);
      chk(rd, 32'h0, "control reset");
      apb(1'b0, 12'h008, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped error");
      apb(1'b1, POF_CTRL_OFS, 32'h0000000b);
      apb(1'b0, POF_CTRL_OFS, 32'h0);
      chk(rd, 32'h0000000b, "control readback");
    end
  endtask

  // Unprocessed formats carry each sample uninterpolated, the 8-bit one as its top eight bits; the 16-bit one goes high byte first under stalls.
  task automatic t_raw();
    logic [11:0] d;
    int i;
    begin
      for (i = 0; i < 8; i++)
      begin
        d = 12'ha5c + 12'(i) * 12'h123;
        exp_q.push_back(d[11:4]);
      end
      send_frame(4, 2, 12'ha5c, 12'h123);
      check_out("raw 8 bytes");
      slow <= 1'b1;
      apb(1'b1, POF_CTRL_OFS, 32'h0000000c);
      for (i = 0; i < 8; i++)
      begin
        d = 12'hf3e + 12'(i) * 12'h2d1;
        exp_q.push_back({4'h0, d[11:8]});
        exp_q.push_back(d[7:0]);
      end
      send_frame(4, 2, 12'hf3e, 12'h2d1);
      check_out("raw 16 words");
      slow <= 1'b0;
    end
  endtask

  // A flat frame gives equal red, green and blue, so luma equals the level and both chroma sit at 128.
  task automatic t_colour();
    int i;
    begin
      apb(1'b1, POF_CTRL_OFS, 32'h0000000a);
      for (i = 0; i < 4; i++)
      begin
        exp_q.push_back(8'h80);
        exp_q.push_back(8'h6c);
        exp_q.push_back(8'h80);
        exp_q.push_back(8'h6c);
      end
      send_frame(4, 2, 12'h6c0, 12'h0);
      check_out("luma chroma pairs");
      apb(1'b1, POF_CTRL_OFS, 32'h00000008);
      for (i = 0; i < 8; i++)
      begin
        exp_q.push_back(8'h9a);
      end
      send_frame(4, 2, 12'h9a0, 12'h0);
      check_out("colour gray 8");
      apb(1'b1, POF_CTRL_OFS, 32'h00000009);
      for (i = 0; i < 8; i++)
      begin
        exp_q.push_back(8'h09);
        exp_q.push_back(8'ha7);
      end
      send_frame(4, 2, 12'h9a7, 12'h0);
      check_out("colour gray 16");
    end
  endtask

  // An undefined format code is flagged and falls back to gray 8; six frames have started so far.
  task automatic t_bad();
    int i;
    begin
      apb(1'b1, POF_CTRL_OFS, 32'h0000000d);
      for (i = 0; i < 8; i++)
      begin
        exp_q.push_back(8'h33);
      end
      send_frame(4, 2, 12'h330, 12'h0);
      check_out("fallback gray 8");
      apb(1'b0, POF_STATUS_OFS, 32'h0);
      chk(rd & 32'hffff001f, 32'h00060001, "status word");
    end
  endtask

  // A hang is cut short well above the expected run length.
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  // Reset for eight cycles, then the scenarios in turn.
  initial
  begin
    n_mismatch = 0;
    cmp_count = 0;
    cycles = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pix_in = '0;
    pix_valid = 1'b0;
    slow = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_raw();
    t_colour();
    t_bad();
    complete_run();
  end
endmodule // pixel_output_formatter_bench
